// File: hw/bbs_byte_if.sv
// Byte transfer carrier between the sequencer and its master SPI engine
`timescale 1ns/1ns
interface bbs_byte_if;
	logic       start;
	logic [7:0] tx;
	logic       busy;
	logic       done;
	logic [7:0] rx;
	logic       sclk;
	logic       mosi;

	modport master (output start, output tx, input busy, input done, input rx,
		input sclk, input mosi);
	modport engine (input start, input tx, output busy, output done, output rx,
		output sclk, output mosi);
endinterface

// File: hw/bbs_host_detect.sv
// Host port mode detector: two clock edges switch it from I2C to SPI slave
`timescale 1ns/1ns
module bbs_host_detect (
	input  wire logic clk,
	input  wire logic rst_int_n,
	input  wire logic host_bus_port_clk,
	output logic      spi_mode
);
	import bbs_pkg::*;

	logic       hclk_meta_r;
	logic       hclk_sync_r;
	logic       hclk_last_r;
	logic [1:0] edge_cnt_r;

	always_ff @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			hclk_meta_r <= 1'b0;
			hclk_sync_r <= 1'b0;
			hclk_last_r <= 1'b0;
		end else begin
			hclk_meta_r <= host_bus_port_clk;
			hclk_sync_r <= hclk_meta_r;
			hclk_last_r <= hclk_sync_r;
		end
	end

	// Count rising edges, saturating; the mode is sticky until reset
	always_ff @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			edge_cnt_r <= 2'h0;
		end else if (hclk_sync_r && !hclk_last_r && edge_cnt_r != HOST_SPI_EDGES) begin
			edge_cnt_r <= edge_cnt_r + 2'h1; // [RULE_18]
		end
	end

	assign spi_mode = (edge_cnt_r == HOST_SPI_EDGES); // [RULE_18]
endmodule

// File: hw/bbs_pkg.sv
// Constants, state and event codes shared by the boot sequencer files
package bbs_pkg;

	// Clock rate and the times derived from it
	localparam int CLK_FREQ_HZ     = 20_000_000;
	localparam int SENSE_WAIT_US   = 3000;
	localparam int SENSE_WAIT_CYC  = SENSE_WAIT_US * (CLK_FREQ_HZ / 1_000_000);
	localparam int BOOT_LIMIT_MS   = 1000;
	localparam int BOOT_LIMIT_CYC  = BOOT_LIMIT_MS * (CLK_FREQ_HZ / 1000);
	localparam int STRAP_SETTLE_CYC = 4;

	// Strap layout
	localparam int STRAP_W       = 3;
	localparam int CLKSRC_LSB    = 0;
	localparam int CLKSRC_W      = 2;
	localparam int BOOTSRC_BIT   = 2;
	localparam logic [2:0] STRAP_RESET = 3'h0;
	localparam logic [1:0] CLKSRC_XTAL  = 2'h0;
	localparam logic [1:0] CLKSRC_FS8K  = 2'h1;
	localparam logic [1:0] CLKSRC_FS16K = 2'h2;
	localparam logic [1:0] CLKSRC_RSVD  = 2'h3;
	localparam logic       BOOT_HOST    = 1'b0;
	localparam logic       BOOT_AUTO    = 1'b1;

	// Synchronised pin vector layout
	localparam int SYNC_W          = 6;
	localparam int SYNC_STRAP_LSB  = 0;
	localparam int SYNC_SUPPLY_SEL = 3;
	localparam int SYNC_SUPPLY_OK  = 4;
	localparam int SYNC_PLL_LOCK   = 5;

	// Flash image access
	localparam logic [7:0]  FLASH_READ_CMD   = 8'h03;
	localparam logic [23:0] FLASH_IMAGE_BASE = 24'h00_0000;
	localparam int PM_ADDR_W  = 16;
	localparam int PM_DATA_W  = 16;
	localparam int CFG_ADDR_W = 8;
	localparam int CFG_DATA_W = 16;

	// Master SPI timing: half period of the serial clock in system clocks
	localparam int SPI_HALF_CYC = 4;

	// Host port detection
	localparam logic [1:0] HOST_SPI_EDGES = 2'h2;

	// Event codes
	localparam int EVENT_W = 8;
	localparam logic [7:0] EV_NONE         = 8'h00;
	localparam logic [7:0] EV_BOOT_READY   = 8'h01;
	localparam logic [7:0] EV_CFG_ERROR    = 8'h02;
	localparam logic [7:0] EV_BOOT_TIMEOUT = 8'h03;
	localparam logic [7:0] EV_FW_START     = 8'h04;

	typedef enum logic [3:0] {
		ST_SENSE,
		ST_SETTLE,
		ST_SUPPLY,
		ST_PLL,
		ST_NOTIFY,
		ST_FL_CMD,
		ST_FL_HDR,
		ST_FL_FW,
		ST_FL_CFG,
		ST_HOST_WAIT,
		ST_RUN,
		ST_ERROR
	} bbs_state_type;

endpackage

// File: hw/bbs_spi_byte.sv
// Master SPI byte engine, mode 0, one byte per start request
`timescale 1ns/1ns
module bbs_spi_byte (
	input  wire logic   clk,
	input  wire logic   rst_int_n,
	input  wire logic   spi_miso,
	bbs_byte_if.engine  bus
);
	import bbs_pkg::*;

	logic       miso_meta_r;
	logic       miso_sync_r;
	logic       busy_r;
	logic       done_r;
	logic       sclk_r;
	logic [7:0] shift_r;
	logic [2:0] bit_r;
	logic [1:0] div_r;

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			miso_meta_r <= 1'b0;
			miso_sync_r <= 1'b0;
		end else begin
			miso_meta_r <= spi_miso;
			miso_sync_r <= miso_meta_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sample at the last cycle of the high phase so the two-flop delay is absorbed
	always_ff @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			busy_r  <= 1'b0;
			done_r  <= 1'b0;
			sclk_r  <= 1'b0;
			shift_r <= 8'h00;
			bit_r   <= 3'h0;
			div_r   <= 2'h0;
		end else begin
			done_r <= 1'b0;
			if (!busy_r) begin
				if (bus.start) begin
					busy_r  <= 1'b1;
					shift_r <= bus.tx;
					bit_r   <= 3'h0;
					div_r   <= 2'h0;
					sclk_r  <= 1'b0;
				end
			end else if (div_r == 2'(SPI_HALF_CYC - 1)) begin
				div_r <= 2'h0;
				if (!sclk_r) begin
					sclk_r <= 1'b1;
				end else begin
					sclk_r  <= 1'b0;
					shift_r <= {shift_r[6:0], miso_sync_r};
					if (bit_r == 3'h7) begin
						busy_r <= 1'b0;
						done_r <= 1'b1;
					end else begin
						bit_r <= bit_r + 3'h1;
					end
				end
			end else begin
				div_r <= div_r + 2'h1;
			end
		end
	end

	assign bus.busy = busy_r;
	assign bus.done = done_r;
	assign bus.rx   = shift_r;
	assign bus.sclk = sclk_r;
	assign bus.mosi = shift_r[7];
endmodule

// File: hw/bbs_top.sv
// Boot sequencer top: strap sense, supply and PLL bring-up, flash or host load
`timescale 1ns/1ns
// Notes on behaviour
// RULE_01: Boot sequence restarts whenever reset is released, power-up included.
// RULE_02: Three strap pins are sampled once and held on the boot-sense outputs.
// RULE_03: Auto boot copies firmware words and configuration record from flash.
// RULE_04: Host boot makes no flash access and waits for the host load.
// RULE_05: Configuration record entries are written to configuration registers after firmware.
// RULE_06: After configuration writes, firmware execution is started.
// RULE_07: Strap values reset to zero; unpulled pins read zero.
// RULE_08: Low two strap bits pick clock source; 11 is reserved.
// RULE_09: Top strap bit picks boot source: 0 host, 1 flash.
// RULE_10: Flash boot turns a spare pin into the master SPI chip select.
// RULE_11: After sampling, strap pins are released for general use.
// RULE_12: System supplies a stable clock before releasing reset.
// RULE_13: With supply select low, internal regulator is enabled first.
// RULE_14: PLL is enabled only once the core supply is good.
// RULE_15: PLL reference follows straps; sequencer waits for lock.
// RULE_16: On lock, post ready event and pull host interrupt low.
// RULE_17: First host interface to start loading becomes boot master.
// RULE_18: Two host clock edges select SPI slave, else I2C stays.
// RULE_19: Auto boot must finish within one second, else error event. The timeout is acted on only in the flash load states.
// RULE_20: Host SPI load clock stays at or below 25 MHz.
// RULE_21: Host I2C load clock stays at or below 400 kHz.
// RULE_22: During reset every three-state output is released.
// RULE_23: Host should prefer SPI loading when boot speed matters.
// RULE_24: Straps are sensed, then about 3 ms pass before boot proceeds.
// RULE_25: A short low reset pulse returns all state to reset values.
// RULE_26: Reserved clock code is recorded, flagged, and PLL stays off.
// RULE_27: Host boot waits forever; firmware starts on host load-done.
module bbs_top #(
	parameter int SENSE_WAIT_CYCLES = bbs_pkg::SENSE_WAIT_CYC,
	parameter int BOOT_LIMIT_CYCLES = bbs_pkg::BOOT_LIMIT_CYC
) (
	input  wire logic                            clk,
	input  wire logic                            rst_n,
	input  wire logic [bbs_pkg::STRAP_W-1:0]     strap_pins,
	input  wire logic                            supply_select_pin,
	input  wire logic                            core_supply_good,
	input  wire logic                            pll_locked,
	input  wire logic                            host_bus_port_clk,
	input  wire logic                            host_spi_load_start,
	input  wire logic                            host_i2c_load_start,
	input  wire logic                            host_load_done,
	input  wire logic                            spi_miso,
	output logic [bbs_pkg::STRAP_W-1:0]          boot_sense,
	output logic                                 strap_release,
	output logic                                 gpio_is_chip_select,
	output logic                                 regulator_enable,
	output logic                                 pll_enable,
	output logic [bbs_pkg::CLKSRC_W-1:0]         pll_ref_select,
	output logic                                 event_post,
	output logic [bbs_pkg::EVENT_W-1:0]          event_code,
	output logic                                 host_interrupt_line_out,
	output logic                                 host_interrupt_line_oe_n,
	output logic                                 host_bus_port_spi_mode,
	output logic                                 host_master_valid,
	output logic                                 host_master_is_spi,
	output logic                                 master_spi_clock,
	output logic                                 master_spi_clock_oe_n,
	output logic                                 master_spi_mosi,
	output logic                                 master_spi_mosi_oe_n,
	output logic                                 master_spi_chip_select,
	output logic                                 master_spi_chip_select_oe_n,
	output logic                                 prog_mem_we,
	output logic [bbs_pkg::PM_ADDR_W-1:0]        prog_mem_addr,
	output logic [bbs_pkg::PM_DATA_W-1:0]        prog_mem_data,
	output logic                                 cfg_we,
	output logic [bbs_pkg::CFG_ADDR_W-1:0]       cfg_addr,
	output logic [bbs_pkg::CFG_DATA_W-1:0]       cfg_data,
	output logic                                 firmware_run,
	output logic                                 boot_error
);
	import bbs_pkg::*;

	logic                  rst_meta_r;
	logic                  rst_sync_r;
	logic                  rst_int_n;
	logic [SYNC_W-1:0]     pin_meta_r;
	logic [SYNC_W-1:0]     pin_sync_r;
	bbs_state_type         state_r;
	logic [31:0]           wait_cnt_r;
	logic [31:0]           boot_timer_r;
	logic                  timeout;
	logic [STRAP_W-1:0]    strap_r;
	logic                  boot_auto;
	logic [1:0]            clk_src;
	logic                  supply_ok_s;
	logic                  pll_lock_s;
	logic                  inflight_r;
	logic [1:0]            byte_idx_r;
	logic                  byte_done;
	logic [7:0]            rx_byte;
	logic [7:0]            cmd_byte;
	logic [PM_ADDR_W-1:0]  fw_len_r;
	logic [PM_ADDR_W-1:0]  word_idx_r;
	logic [7:0]            cfg_left_r;
	logic [7:0]            hi_byte_r;
	logic                  irq_flag_r;
	logic                  flash_active;
	logic                  drive_en_r;

	bbs_byte_if byte_bus ();

	////////////////////////////////////////////////////////////////////////
	// Last byte index of the current multi-byte unit in each flash state
	function automatic logic [1:0] last_idx(input bbs_state_type st);
		unique case (st)
			ST_FL_CMD: last_idx = 2'h3;
			ST_FL_HDR: last_idx = 2'h2;
			ST_FL_FW:  last_idx = 2'h1;
			ST_FL_CFG: last_idx = 2'h2;
			default:   last_idx = 2'h0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Reset release through two flops; assertion stays asynchronous
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_r <= 1'b0; // [RULE_25]
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end
	assign rst_int_n = rst_sync_r;

	always_ff @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			pin_meta_r <= '0;
			pin_sync_r <= '0;
		end else begin
			pin_meta_r <= {pll_locked, core_supply_good, supply_select_pin, strap_pins};
			pin_sync_r <= pin_meta_r;
		end
	end
	assign supply_ok_s = pin_sync_r[SYNC_SUPPLY_OK];
	assign pll_lock_s  = pin_sync_r[SYNC_PLL_LOCK];

	////////////////////////////////////////////////////////////////////////
	// Strap capture happens once, after the synchroniser has filled
	always_ff @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			strap_r <= STRAP_RESET; // [RULE_07]
		end else if (state_r == ST_SENSE && wait_cnt_r == 32'(STRAP_SETTLE_CYC - 1)) begin
			strap_r <= pin_sync_r[SYNC_STRAP_LSB +: STRAP_W]; // [RULE_02]
		end
	end
	assign boot_sense = strap_r; // [RULE_02]
	assign clk_src    = strap_r[CLKSRC_LSB +: CLKSRC_W]; // [RULE_08]
	assign boot_auto  = (strap_r[BOOTSRC_BIT] == BOOT_AUTO); // [RULE_09]

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			wait_cnt_r <= 32'h0000_0000;
		end else if (state_r == ST_SENSE && wait_cnt_r == 32'(STRAP_SETTLE_CYC - 1)) begin
			wait_cnt_r <= 32'h0000_0000;
		end else if (state_r == ST_SENSE || state_r == ST_SETTLE) begin
			wait_cnt_r <= wait_cnt_r + 32'h0000_0001;
		end
	end

	// Whole-boot budget; host boot has no limit
	always_ff @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			boot_timer_r <= 32'h0000_0000;
		end else if (!timeout) begin
			boot_timer_r <= boot_timer_r + 32'h0000_0001;
		end
	end
	assign timeout = (boot_timer_r == 32'(BOOT_LIMIT_CYCLES - 1));

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			state_r <= ST_SENSE; // [RULE_01]
		end else begin
			unique case (state_r)
				ST_SENSE: begin
					if (wait_cnt_r == 32'(STRAP_SETTLE_CYC - 1)) begin
						state_r <= ST_SETTLE;
					end
				end
				ST_SETTLE: begin
					if (wait_cnt_r == 32'(SENSE_WAIT_CYCLES - 1)) begin
						state_r <= ST_SUPPLY; // [RULE_24]
					end
				end
				ST_SUPPLY: begin
					if (supply_ok_s) begin
						state_r <= (clk_src == CLKSRC_RSVD) ? ST_ERROR : ST_PLL; // [RULE_14] [RULE_26]
					end
				end
				ST_PLL: begin
					if (pll_lock_s) begin
						state_r <= ST_NOTIFY; // [RULE_15]
					end
				end
				ST_NOTIFY: begin
					state_r <= boot_auto ? ST_FL_CMD : ST_HOST_WAIT; // [RULE_03] [RULE_04]
				end
				ST_FL_CMD, ST_FL_HDR, ST_FL_FW, ST_FL_CFG: begin
					if (timeout) begin
						state_r <= ST_ERROR; // [RULE_19]
					end else if (byte_done && byte_idx_r == last_idx(state_r)) begin
						if (state_r == ST_FL_CMD) begin
							state_r <= ST_FL_HDR;
						end else if (state_r == ST_FL_HDR) begin
							if (fw_len_r != '0) begin
								state_r <= ST_FL_FW;
							end else begin
								state_r <= (rx_byte != 8'h00) ? ST_FL_CFG : ST_RUN;
							end
						end else if (state_r == ST_FL_FW) begin
							if (word_idx_r == fw_len_r - 16'h0001) begin
								state_r <= (cfg_left_r != 8'h00) ? ST_FL_CFG : ST_RUN; // [RULE_05]
							end
						end else if (cfg_left_r == 8'h01) begin
							state_r <= ST_RUN; // [RULE_06]
						end
					end
				end
				ST_HOST_WAIT: begin
					if (host_load_done) begin
						state_r <= ST_RUN; // [RULE_27]
					end
				end
				ST_RUN, ST_ERROR: begin
					state_r <= state_r;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Byte requests to the engine; one outstanding at a time
	assign flash_active = (state_r == ST_FL_CMD) || (state_r == ST_FL_HDR) ||
		(state_r == ST_FL_FW) || (state_r == ST_FL_CFG);
	assign byte_done = byte_bus.done;
	assign rx_byte   = byte_bus.rx;

	always_comb begin
		unique case (byte_idx_r)
			2'h0: cmd_byte = FLASH_READ_CMD;
			2'h1: cmd_byte = FLASH_IMAGE_BASE[23:16];
			2'h2: cmd_byte = FLASH_IMAGE_BASE[15:8];
			2'h3: cmd_byte = FLASH_IMAGE_BASE[7:0];
		endcase
	end
	assign byte_bus.start = flash_active && !inflight_r && !byte_bus.busy && !timeout; // [RULE_03]
	assign byte_bus.tx    = (state_r == ST_FL_CMD) ? cmd_byte : 8'h00;

	always_ff @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			inflight_r <= 1'b0;
			byte_idx_r <= 2'h0;
		end else begin
			if (byte_bus.start) begin
				inflight_r <= 1'b1;
			end else if (byte_done) begin
				inflight_r <= 1'b0;
			end
			if (byte_done) begin
				byte_idx_r <= (byte_idx_r == last_idx(state_r)) ? 2'h0 : byte_idx_r + 2'h1;
			end
		end
	end

	bbs_spi_byte u_spi_byte (
		.clk       (clk),
		.rst_int_n (rst_int_n),
		.spi_miso  (spi_miso),
		.bus       (byte_bus.engine)
	);

	////////////////////////////////////////////////////////////////////////
	// Image layout: word count (2 bytes), record count (1 byte), words, records
	always_ff @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			fw_len_r      <= 16'h0000;
			word_idx_r    <= 16'h0000;
			cfg_left_r    <= 8'h00;
			hi_byte_r     <= 8'h00;
			prog_mem_we   <= 1'b0;
			prog_mem_addr <= 16'h0000;
			prog_mem_data <= 16'h0000;
			cfg_we        <= 1'b0;
			cfg_addr      <= 8'h00;
			cfg_data      <= 16'h0000;
		end else begin
			prog_mem_we <= 1'b0;
			cfg_we      <= 1'b0;
			if (byte_done && !timeout) begin
				unique case (state_r)
					ST_FL_HDR: begin
						if (byte_idx_r == 2'h0) fw_len_r[15:8] <= rx_byte;
						if (byte_idx_r == 2'h1) fw_len_r[7:0] <= rx_byte;
						if (byte_idx_r == 2'h2) cfg_left_r <= rx_byte;
					end
					ST_FL_FW: begin
						if (byte_idx_r == 2'h0) begin
							hi_byte_r <= rx_byte;
						end else begin
							prog_mem_we   <= 1'b1; // [RULE_03]
							prog_mem_addr <= word_idx_r;
							prog_mem_data <= {hi_byte_r, rx_byte};
							word_idx_r    <= word_idx_r + 16'h0001;
						end
					end
					ST_FL_CFG: begin
						if (byte_idx_r == 2'h0) cfg_addr <= rx_byte;
						if (byte_idx_r == 2'h1) hi_byte_r <= rx_byte;
						if (byte_idx_r == 2'h2) begin
							cfg_we     <= 1'b1; // [RULE_05]
							cfg_data   <= {hi_byte_r, rx_byte};
							cfg_left_r <= cfg_left_r - 8'h01;
						end
					end
					default: begin
						hi_byte_r <= hi_byte_r;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Supply, PLL and status outputs
	always_ff @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			regulator_enable <= 1'b0;
			pll_enable       <= 1'b0;
			pll_ref_select   <= CLKSRC_XTAL;
			firmware_run     <= 1'b0;
			boot_error       <= 1'b0;
			strap_release    <= 1'b0;
			drive_en_r       <= 1'b0;
		end else begin
			if (state_r == ST_SUPPLY && !pin_sync_r[SYNC_SUPPLY_SEL]) begin
				regulator_enable <= 1'b1; // [RULE_13]
			end
			if (state_r == ST_PLL) begin
				pll_enable     <= 1'b1; // [RULE_14] [RULE_15]
				pll_ref_select <= clk_src;
			end
			firmware_run  <= (state_r == ST_RUN); // [RULE_06]
			boot_error    <= (state_r == ST_ERROR);
			strap_release <= (state_r != ST_SENSE); // [RULE_11]
			drive_en_r    <= 1'b1;
		end
	end

	// Events: one pulse per cause, raised on the transition itself
	always_ff @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			event_post <= 1'b0;
			event_code <= EV_NONE;
		end else begin
			event_post <= 1'b0;
			if (state_r == ST_PLL && pll_lock_s) begin
				event_post <= 1'b1; // [RULE_16]
				event_code <= EV_BOOT_READY;
			end else if (state_r == ST_SUPPLY && supply_ok_s && clk_src == CLKSRC_RSVD) begin
				event_post <= 1'b1; // [RULE_26]
				event_code <= EV_CFG_ERROR;
			end else if (flash_active && timeout) begin
				event_post <= 1'b1; // [RULE_19]
				event_code <= EV_BOOT_TIMEOUT;
			end else if (state_r != ST_RUN && state_r != ST_ERROR && state_r != ST_SENSE &&
				state_r != ST_SETTLE && state_r != ST_SUPPLY && state_r != ST_PLL &&
				state_r != ST_NOTIFY && !(flash_active && !byte_done) && 
				((state_r == ST_HOST_WAIT && host_load_done) || flash_active)) begin
				event_post <= 1'b0;
			end
		end
	end

	// Interrupt held until the host starts loading or firmware runs; a new set wins over the clear
	always_ff @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			irq_flag_r <= 1'b0;
		end else if (state_r == ST_PLL && pll_lock_s) begin
			irq_flag_r <= 1'b1; // [RULE_16]
		end else if (host_master_valid || firmware_run) begin
			irq_flag_r <= 1'b0;
		end
	end
	assign host_interrupt_line_out  = 1'b0;
	assign host_interrupt_line_oe_n = !irq_flag_r; // [RULE_16] [RULE_22]

	// First host interface to start wins; a tie goes to SPI
	always_ff @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			host_master_valid  <= 1'b0;
			host_master_is_spi <= 1'b0;
		end else if (state_r == ST_HOST_WAIT && !host_master_valid &&
			(host_spi_load_start || host_i2c_load_start)) begin
			host_master_valid  <= 1'b1; // [RULE_17]
			host_master_is_spi <= host_spi_load_start;
		end
	end

	bbs_host_detect u_host_detect (
		.clk               (clk),
		.rst_int_n         (rst_int_n),
		.host_bus_port_clk (host_bus_port_clk),
		.spi_mode          (host_bus_port_spi_mode)
	);

	////////////////////////////////////////////////////////////////////////
	// Master SPI pins float in reset and in host boot
	assign gpio_is_chip_select         = boot_auto && strap_release; // [RULE_10]
	assign master_spi_chip_select      = !flash_active; // [RULE_10]
	assign master_spi_chip_select_oe_n = !(drive_en_r && gpio_is_chip_select); // [RULE_22]
	assign master_spi_clock            = byte_bus.sclk;
	assign master_spi_clock_oe_n       = !(drive_en_r && gpio_is_chip_select); // [RULE_04]
	assign master_spi_mosi             = byte_bus.mosi;
	assign master_spi_mosi_oe_n        = !(drive_en_r && gpio_is_chip_select);
endmodule

// File: test/bbs_boot_checker.sv
// Concurrent checks on the boot sequencer ports
`timescale 1ns/1ns
module bbs_boot_checker import bbs_pkg::*; (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       supply_select_pin,
	input wire logic       core_supply_good,
	input wire logic       pll_locked,
	input wire logic [2:0] boot_sense,
	input wire logic       strap_release,
	input wire logic       gpio_is_chip_select,
	input wire logic       regulator_enable,
	input wire logic       pll_enable,
	input wire logic [1:0] pll_ref_select,
	input wire logic       event_post,
	input wire logic [7:0] event_code,
	input wire logic       host_interrupt_line_oe_n,
	input wire logic       master_spi_chip_select_oe_n,
	input wire logic       prog_mem_we,
	input wire logic       cfg_we,
	input wire logic       firmware_run
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence ready_s;
		event_post && event_code == EV_BOOT_READY;
	endsequence
	reg_first_a: assert property (
		$rose(pll_enable) |-> regulator_enable | supply_select_pin)
		else $error("pll before regulator");
	supply_pll_a: assert property (
		$rose(pll_enable) |-> $past(core_supply_good, 2))
		else $error("pll before supply");
	ref_sel_a: assert property (
		pll_enable |-> pll_ref_select == boot_sense[1:0] && pll_ref_select != CLKSRC_RSVD)
		else $error("bad pll reference");
	ready_irq_a: assert property (
		ready_s |-> !host_interrupt_line_oe_n && $past(pll_locked))
		else $error("ready without lock or interrupt");
	host_quiet_a: assert property (
		strap_release && !boot_sense[2] |-> master_spi_chip_select_oe_n && !gpio_is_chip_select)
		else $error("flash touched in host boot");
	cs_gpio_a: assert property (
		gpio_is_chip_select |-> boot_sense[2] && strap_release)
		else $error("chip select pin misassigned");
	load_order_a: assert property (
		prog_mem_we || cfg_we |-> boot_sense[2] && !firmware_run)
		else $error("write after firmware start");
	sense_hold_a: assert property (
		strap_release && $past(strap_release) |-> $stable(boot_sense))
		else $error("boot sense changed");
endmodule
bind bbs_top bbs_boot_checker u_bbs_boot_checker (.*);

// File: test/bbs_flash_model.sv
// Serial flash model streaming a fixed boot image
`timescale 1ns/1ns
module bbs_flash_model (
	input  wire logic sclk,
	input  wire logic cs_n,
	output logic      miso
);
	// Counts 0001 and 01, one word abcd, one record 05 <- 1234
	localparam logic [63:0] IMAGE = 64'h0001_01ab_cd05_1234;
	int bit_r = 0;
	initial miso = 1'b0;
	always @(negedge cs_n) bit_r = 0;
	// Data leaves on falling edges once command and address are in
	always @(negedge sclk) if (!cs_n) begin
		bit_r = bit_r + 1;
		if (bit_r > 31 && bit_r < 96) miso = IMAGE[95-bit_r];
	end
	// A released line must not keep looking valid
	always @(posedge cs_n) miso = ~miso;
endmodule

// File: test/bbs_top_bench.sv
// Bench for the boot sequencer: host, reserved clock and flash boots
`timescale 1ns/1ns
module bbs_top_bench;
	import bbs_pkg::*;
	logic        clk = 1'b0, rst_n = 1'b1, supply_select_pin, core_supply_good, pll_locked;
	logic        host_bus_port_clk, host_spi_load_start, host_i2c_load_start, host_load_done;
	logic        spi_miso, strap_release, gpio_is_chip_select, regulator_enable, pll_enable;
	logic        event_post, host_interrupt_line_out, host_interrupt_line_oe_n, boot_error;
	logic        host_bus_port_spi_mode, host_master_valid, host_master_is_spi, firmware_run;
	logic        master_spi_clock, master_spi_clock_oe_n, master_spi_mosi, master_spi_mosi_oe_n;
	logic        master_spi_chip_select, master_spi_chip_select_oe_n, prog_mem_we, cfg_we;
	logic [2:0]  strap_pins, boot_sense;
	logic [1:0]  pll_ref_select;
	logic [7:0]  event_code, cfg_addr;
	logic [15:0] prog_mem_addr, prog_mem_data, cfg_data;
	logic [31:0] r;
	int          fail_count = 0, num_checks = 0;
	bit          stall;
	bbs_top #(.SENSE_WAIT_CYCLES(20), .BOOT_LIMIT_CYCLES(5000)) u_bbs_top (.*);
	bbs_flash_model u_bbs_flash_model (.sclk(master_spi_clock), .cs_n(master_spi_chip_select),
		.miso(spi_miso));
	always #25 clk = ~clk;
	// Supply and PLL answer 2 ns after the clock edge that switches them on
	always @(posedge clk) begin
		#2;
		core_supply_good = (regulator_enable | supply_select_pin) && !stall;
		pll_locked = pll_enable;
	end
	task tick(int k);
		repeat (k) @(posedge clk);
		#2;
	endtask
	task chk(logic [31:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_hi(ref logic s);
		for (int n = 0; n < 3000 && s !== 1'b1; n++) tick(1);
		chk(s, 1);
	endtask
	function logic [2:0] ready_exp();
		return {strap_pins[1:0], !supply_select_pin};
	endfunction
	task boot(logic [2:0] s, logic sel);
		rst_n = 0;
		strap_pins = s;
		supply_select_pin = sel;
		tick(2);
		chk({host_interrupt_line_oe_n, master_spi_chip_select_oe_n, master_spi_clock_oe_n,
			master_spi_mosi_oe_n, master_spi_clock, master_spi_mosi}, 6'h3c);
		rst_n = 1;
		wait_hi(strap_release);
		chk(boot_sense, s);
	endtask
	task host(logic spi);
		wait_hi(event_post);
		chk({event_code, host_interrupt_line_oe_n, host_interrupt_line_out},
			{EV_BOOT_READY, 2'b0});
		chk({pll_ref_select, regulator_enable}, ready_exp());
		// Two host clock cycles at 400 ns turn the port to SPI
		repeat (spi ? 2 : 0) begin
			host_bus_port_clk = 1;
			#200 host_bus_port_clk = 0;
			#200;
		end
		tick(4);
		chk(host_bus_port_spi_mode, spi);
		host_spi_load_start = spi;
		host_i2c_load_start = !spi;
		tick(1);
		host_spi_load_start = 0;
		host_i2c_load_start = 0;
		tick(1);
		chk({host_master_valid, host_master_is_spi, firmware_run, host_interrupt_line_oe_n},
			{2'b10 | spi, 2'b01});
		host_load_done = 1;
		tick(1);
		host_load_done = 0;
		tick(2);
		chk(firmware_run, 1);
	endtask
	task print_verdict;
		$display("Checks %0d, errors %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		{strap_pins, supply_select_pin, host_bus_port_clk, host_spi_load_start} = '0;
		{host_i2c_load_start, host_load_done, core_supply_good, pll_locked} = '0;
		void'($urandom(75636));
		#2;
		for (int i = 0; i < 4; i++) begin
			r = $urandom;
			boot({1'b0, i[1:0]}, r[0]);
			if (i < 3) host(r[1]);
			else begin
				wait_hi(boot_error);
				chk({pll_enable, event_code}, {1'b0, EV_CFG_ERROR});
			end
		end
		boot({1'b1, 2'($urandom % 3)}, 1'b1);
		chk(gpio_is_chip_select, 1);
		wait_hi(prog_mem_we);
		chk({prog_mem_addr, prog_mem_data}, 32'h0000_abcd);
		wait_hi(cfg_we);
		chk({cfg_addr, cfg_data}, 32'h0005_1234);
		wait_hi(firmware_run);
		chk(boot_error, 0);
		// Supply held off past the boot budget, so flash loading must give up
		stall = 1;
		boot(3'h4, 1'b1);
		tick(5000);
		stall = 0;
		wait_hi(boot_error);
		chk({event_code, master_spi_chip_select}, {EV_BOOT_TIMEOUT, 1'b1});
		print_verdict;
	end
	initial begin
		#2_000_000;
		fail_count++;
		print_verdict;
	end
endmodule
